// *** hdl/fep_pkg.sv ***
// shared constants for the flash sequencer and its controller
// assumes a 16-bit flash address map whose array ends at the top address
`default_nettype none
package fep_pkg;
  // flash map
  localparam logic [15:0] FLASH_BASE  = 16'hee00;
  localparam int          FLASH_BYTES = 4608;
  localparam int          IDX_W       = 13;
  localparam int          PAGE_BYTES  = 64;
  localparam logic [15:0] PROT_ADDR   = 16'hffbe;
  localparam logic [7:0]  ERASED      = 8'hff;
  // flash control byte bit positions
  localparam int CB_PROG  = 0;
  localparam int CB_ERASE = 1;
  localparam int CB_MASS  = 2;
  localparam int CB_HV    = 3;
  // delays in bus clock cycles
  localparam int STEP_W        = 24;
  localparam int SETUP_CYC     = 40;
  localparam int HOLD_CYC      = 20;
  localparam int LONG_HOLD_CYC = 40;
  localparam int ERASE_CYC     = 400;
  localparam int MASS_CYC      = 1600;
  localparam int PGS_CYC       = 20;
  localparam int PROG_CYC      = 12;
  localparam int RCV_CYC       = 4;
  // controller register offsets
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  // command and status fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_CNT_LSB = 4;
  localparam int CMD_GO      = 8;
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_REFUSED  = 2;
  localparam int ST_PROT_LSB = 8;
  localparam int ST_CTL_LSB  = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    OP_PAGE = 2'h0,
    OP_MASS = 2'h1,
    OP_PROG = 2'h2
  } fep_op_e;

  // device sequence tracking, gray along the normal path
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_SEL   = 3'h1,
    D_PROT  = 3'h3,
    D_LATCH = 3'h2,
    D_HV    = 3'h6,
    D_HOLD  = 3'h7
  } fep_dev_e;
endpackage : fep_pkg
`default_nettype wire

// *** hdl/fep_if.sv ***
// link between the sequencing controller and the flash device
// one request at a time; the device answers with a one-cycle ack
`default_nettype none
interface fep_if;
  logic       req;
  logic       we;
  logic       sel_ctl;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport dev (input req, input we, input sel_ctl, input addr, input wdata, output ack, output rdata);
  modport ctl (output req, output we, output sel_ctl, output addr, output wdata, input ack, input rdata);
endinterface : fep_if
`default_nettype wire

// *** hdl/fep_device.sv ***
// flash array end: control byte, sequence interlocks, protection, erase and program
// assumes a single clock and a controller that holds req until it sees ack
//
// Contract
// - page erase covers 64 aligned bytes
// - controller follows page erase step order
// - controller follows mass erase step order
// - mass erase inhibited unless protect byte ff
// - protect byte read before high voltage
// - high voltage refused for protected targets
// - program one aligned 32-byte row
// - program select enables write capture
// - controller follows row program step order
// - byte spacing within maximum program time
// - never program a byte twice unerased
// - no watchdog write while high voltage
// - sequencing code runs outside flash
// - ordered steps, unrelated accesses tolerated
// - protection runs from start to top
// - start address from protect byte bits
// - low values protect all, ff none
// - protect byte changes need test voltage
// - monitor mass erase latches protect address
// - vector page erase loses trim bytes
// - protect byte lives inside the array
// - erase and program selects interlocked
// - high voltage needs select and sequence
`default_nettype none
module fep_device #(
  parameter int SETUP_CYC = fep_pkg::SETUP_CYC,
  parameter int ERASE_CYC = fep_pkg::ERASE_CYC,
  parameter int MASS_CYC  = fep_pkg::MASS_CYC,
  parameter int PGS_CYC   = fep_pkg::PGS_CYC,
  parameter int RCV_CYC   = fep_pkg::RCV_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  fep_if.dev              link,
  input  wire logic       test_high_voltage,
  output logic            hv_active,
  output logic [7:0]      protect_start_byte,
  output logic            busy
);
  localparam int SW = fep_pkg::STEP_W;
  localparam int IW = fep_pkg::IDX_W;

  // nonvolatile array: no reset, erased at power-up
  logic [7:0] mem [fep_pkg::FLASH_BYTES];
  initial begin
    for (int i = 0; i < fep_pkg::FLASH_BYTES; i++) begin
      mem[i] = fep_pkg::ERASED;
    end
  end

  fep_pkg::fep_dev_e state_reg, state_next;
  logic          prog_reg, erase_reg, mass_reg, hv_reg;
  logic [15:0]   latch_reg;
  logic [SW-1:0] step_reg;
  logic [SW-1:0] rcv_reg;
  logic [IW-1:0] wipe_ptr_reg;
  logic [IW-1:0] wipe_left_reg;
  logic          ack_reg;
  logic [7:0]    rdata_reg;

  // protected from {11, byte, 000000} up to the top address
  function automatic logic [15:0] prot_start(input logic [7:0] b);
    return {2'b11, b, 6'h00};
  endfunction : prot_start

  // an all-ones byte protects nothing; low bytes give a start below the array, so all of it
  function automatic logic prot_hit(input logic [15:0] a, input logic [7:0] b, input logic tv);
    logic own_page;
    own_page = a[15:6] == fep_pkg::PROT_ADDR[15:6];
    return (b != fep_pkg::ERASED) && (a >= prot_start(b)) && !(tv && own_page);
  endfunction : prot_hit

  // bus decode; a request already answered is not taken twice
  wire            take     = link.req & ~ack_reg;
  wire            in_flash = link.addr >= fep_pkg::FLASH_BASE;
  wire [IW-1:0]   idx      = IW'(link.addr - fep_pkg::FLASH_BASE);
  wire            ctl_wr   = take & link.we & link.sel_ctl;
  wire            fl_wr    = take & link.we & ~link.sel_ctl & in_flash;
  wire            fl_rd    = take & ~link.we & ~link.sel_ctl;

  // protect byte is an ordinary array location, only changed by erase or program
  assign protect_start_byte = mem[IW'(fep_pkg::PROT_ADDR - fep_pkg::FLASH_BASE)];

  // control byte write: a write asking for both selects changes neither
  wire wd_prog  = link.wdata[fep_pkg::CB_PROG];
  wire wd_erase = link.wdata[fep_pkg::CB_ERASE];
  wire wd_mass  = link.wdata[fep_pkg::CB_MASS];
  wire wd_hv    = link.wdata[fep_pkg::CB_HV];
  wire sel_ok   = ~(wd_prog & wd_erase);
  wire prog_n   = sel_ok ? wd_prog : prog_reg;
  wire erase_n  = sel_ok ? wd_erase : erase_reg;
  wire mass_n   = sel_ok ? wd_mass : mass_reg;

  // high voltage is granted only from a completed latch step with setup time served
  wire mass_block = erase_n & mass_n & (protect_start_byte != fep_pkg::ERASED);
  wire setup_ok   = step_reg >= SW'(SETUP_CYC);
  wire tgt_prot   = prot_hit(latch_reg, protect_start_byte, test_high_voltage);
  wire arm_ok     = (state_reg == fep_pkg::D_LATCH) & setup_ok & (prog_n | erase_n);
  wire hv_n       = wd_hv & (hv_reg | (arm_ok & ~mass_block & ~tgt_prot));

  // erase takes effect when the select drops after the full erase time
  wire [SW-1:0] erase_lim = mass_reg ? SW'(MASS_CYC) : SW'(ERASE_CYC);
  wire erase_ev = ctl_wr & erase_reg & ~erase_n & hv_reg & (state_reg == fep_pkg::D_HV) & (step_reg >= erase_lim);

  // program only bytes of the latched row, after program setup time
  wire same_row = link.addr[15:5] == latch_reg[15:5];
  wire prog_ev  = fl_wr & (state_reg == fep_pkg::D_HV) & prog_reg & (step_reg >= SW'(PGS_CYC)) & same_row &
                  ~prot_hit(link.addr, protect_start_byte, test_high_voltage);

  wire [15:0] page_base = {latch_reg[15:6], 6'h00};
  wire [IW-1:0] page_idx = IW'(page_base - fep_pkg::FLASH_BASE);

  assign busy      = hv_reg | (rcv_reg != '0) | (wipe_left_reg != '0);
  assign hv_active = hv_reg;
  assign link.ack   = ack_reg;
  assign link.rdata = rdata_reg;

  // sequence tracking; other accesses between the steps leave it alone
  always_comb begin
    state_next = state_reg;
    if (ctl_wr) begin
      if (hv_n & ~hv_reg) begin
        state_next = fep_pkg::D_HV;
      end else if (~hv_n & hv_reg) begin
        state_next = fep_pkg::D_IDLE;
      end else if (~prog_n & ~erase_n) begin
        state_next = hv_n ? fep_pkg::D_HOLD : fep_pkg::D_IDLE;
      end else if (state_reg == fep_pkg::D_IDLE) begin
        state_next = fep_pkg::D_SEL;
      end
    end else if (fl_rd & (link.addr == fep_pkg::PROT_ADDR) & (state_reg == fep_pkg::D_SEL)) begin
      state_next = fep_pkg::D_PROT;
    end else if (fl_wr & (state_reg == fep_pkg::D_PROT)) begin
      state_next = fep_pkg::D_LATCH;
    end
  end

  // control byte read view
  logic [7:0] ctl_vec;
  always_comb begin
    ctl_vec = 8'h00;
    ctl_vec[fep_pkg::CB_PROG]  = prog_reg;
    ctl_vec[fep_pkg::CB_ERASE] = erase_reg;
    ctl_vec[fep_pkg::CB_MASS]  = mass_reg;
    ctl_vec[fep_pkg::CB_HV]    = hv_reg;
  end

  // reads of the array during high voltage or recovery see erased data, not a half state
  wire [7:0] fl_data = (~in_flash) ? 8'h00 : (busy ? fep_pkg::ERASED : mem[idx]);

  // control byte and sequence registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= fep_pkg::D_IDLE;
      prog_reg  <= 1'b0;
      erase_reg <= 1'b0;
      mass_reg  <= 1'b0;
      hv_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (ctl_wr) begin
        prog_reg  <= prog_n;
        erase_reg <= erase_n;
        mass_reg  <= mass_n;
        hv_reg    <= hv_n;
      end
    end
  end

  // latched target and step timer, restarted at latch and at high voltage on
  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch_reg <= 16'h0000;
      step_reg  <= '0;
    end else begin
      if (state_next != state_reg && (state_next == fep_pkg::D_LATCH || state_next == fep_pkg::D_HV)) begin
        step_reg <= '0;
      end else if (step_reg != '1) begin
        step_reg <= step_reg + SW'(1);
      end
      if (fl_wr & (state_reg == fep_pkg::D_PROT)) begin
        latch_reg <= link.addr;
      end
    end
  end

  // recovery timer and wipe walker; the walker clears one byte a cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rcv_reg       <= '0;
      wipe_ptr_reg  <= '0;
      wipe_left_reg <= '0;
    end else begin
      if (ctl_wr & hv_reg & ~hv_n) begin
        rcv_reg <= SW'(RCV_CYC);
      end else if (rcv_reg != '0) begin
        rcv_reg <= rcv_reg - SW'(1);
      end
      if (erase_ev) begin
        wipe_ptr_reg  <= mass_reg ? '0 : page_idx;
        wipe_left_reg <= mass_reg ? IW'(fep_pkg::FLASH_BYTES) : IW'(fep_pkg::PAGE_BYTES);
      end else if (wipe_left_reg != '0) begin
        wipe_ptr_reg  <= wipe_ptr_reg + IW'(1);
        wipe_left_reg <= wipe_left_reg - IW'(1);
      end
    end
  end

  // array write port; trim bytes in the vector page are wiped like any other byte
  always @(posedge clk) begin
    if (wipe_left_reg != '0) begin
      mem[wipe_ptr_reg] <= fep_pkg::ERASED;
    end else if (prog_ev) begin
      mem[idx] <= mem[idx] & link.wdata; // programming only clears bits
    end
  end

  // one answer per request, one cycle after it is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= take;
      if (take & ~link.we) begin
        rdata_reg <= link.sel_ctl ? ctl_vec : fl_data;
      end
    end
  end
endmodule : fep_device
`default_nettype wire

// *** hdl/fep_ctrl.sv ***
// sequencing controller: AXI4-Lite registers on one side, the flash link on the other
// assumes the device answers each link request with one ack
`default_nettype none
module fep_ctrl #(
  parameter int SETUP_CYC     = fep_pkg::SETUP_CYC,
  parameter int HOLD_CYC      = fep_pkg::HOLD_CYC,
  parameter int LONG_HOLD_CYC = fep_pkg::LONG_HOLD_CYC,
  parameter int ERASE_CYC     = fep_pkg::ERASE_CYC,
  parameter int MASS_CYC      = fep_pkg::MASS_CYC,
  parameter int PGS_CYC       = fep_pkg::PGS_CYC,
  parameter int PROG_CYC      = fep_pkg::PROG_CYC,
  parameter int RCV_CYC       = fep_pkg::RCV_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  fep_if.ctl               link,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  localparam int SW = fep_pkg::STEP_W;

  typedef enum logic [3:0] {
    C_IDLE = 4'h0, C_SEL = 4'h1, C_RDP = 4'h3, C_LAT = 4'h2, C_NVS = 4'h6, C_HVON = 4'h7,
    C_CHK = 4'h5, C_TOP = 4'h4, C_PWR = 4'hc, C_PWT = 4'hd, C_DESEL = 4'hf, C_HOLD = 4'he,
    C_HVOFF = 4'ha, C_RCV = 4'hb, C_ABORT = 4'h9
  } fep_cst_e;

  fep_cst_e st_reg, st_next;
  fep_pkg::fep_op_e op_reg;
  logic [1:0]    cnt_reg, bix_reg;
  logic [15:0]   addr_reg;
  logic [31:0]   data_reg;
  logic          done_reg, refused_reg;
  logic [7:0]    prot_reg, devctl_reg;
  logic [SW-1:0] wait_reg;
  logic          aw_held, w_held;
  logic [7:0]    awaddr_reg;
  logic [31:0]   wdata_reg;
  logic [3:0]    wstrb_reg;

  function automatic logic [7:0] ctl_byte(input logic p, input logic e, input logic m, input logic h);
    logic [7:0] v;
    v = 8'h00;
    v[fep_pkg::CB_PROG]  = p;
    v[fep_pkg::CB_ERASE] = e;
    v[fep_pkg::CB_MASS]  = m;
    v[fep_pkg::CB_HV]    = h;
    return v;
  endfunction : ctl_byte

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction : merge

  // AXI write side: address and data held independently, applied together
  wire wr_fire  = aw_held & w_held & ~bvalid;
  wire busy     = st_reg != C_IDLE;
  wire hit_cmd  = awaddr_reg == fep_pkg::REG_CMD;
  wire wr_map   = hit_cmd | awaddr_reg == fep_pkg::REG_ADDR | awaddr_reg == fep_pkg::REG_DATA |
                  awaddr_reg == fep_pkg::REG_STAT;
  wire go       = wr_fire & hit_cmd & wstrb_reg[1] & wdata_reg[fep_pkg::CMD_GO] & ~busy;
  wire rd_map   = araddr == fep_pkg::REG_CMD | araddr == fep_pkg::REG_ADDR | araddr == fep_pkg::REG_DATA |
                  araddr == fep_pkg::REG_STAT;
  assign awready = ~aw_held;
  assign wready  = ~w_held;
  assign arready = ~rvalid;

  // selects for the current operation
  wire is_prog = op_reg == fep_pkg::OP_PROG;
  wire is_mass = op_reg == fep_pkg::OP_MASS;
  wire [7:0] sel_b = ctl_byte(is_prog, ~is_prog, is_mass, 1'b0);
  wire [7:0] hv_b  = ctl_byte(is_prog, ~is_prog, is_mass, 1'b1);

  // link request from state; steps are issued strictly in order
  assign link.req = st_reg inside {C_SEL, C_RDP, C_LAT, C_HVON, C_CHK, C_PWR, C_DESEL, C_HVOFF, C_ABORT};
  assign link.we  = st_reg != C_RDP && st_reg != C_CHK;
  assign link.sel_ctl = !(st_reg inside {C_RDP, C_LAT, C_PWR});
  assign link.addr = (st_reg == C_RDP) ? fep_pkg::PROT_ADDR : (st_reg == C_PWR) ? addr_reg + 16'(bix_reg) : addr_reg;
  always_comb begin
    case (st_reg)
      C_SEL:   link.wdata = sel_b;
      C_HVON:  link.wdata = hv_b;
      C_PWR:   link.wdata = data_reg[8*bix_reg +: 8];
      C_DESEL: link.wdata = ctl_byte(1'b0, 1'b0, 1'b0, 1'b1);
      default: link.wdata = (st_reg == C_LAT) ? fep_pkg::ERASED : 8'h00;
    endcase
  end

  // wait limit for the timed states
  logic [SW-1:0] lim;
  always_comb begin
    case (st_reg)
      C_NVS:   lim = SW'(SETUP_CYC);
      C_TOP:   lim = is_prog ? SW'(PGS_CYC) : (is_mass ? SW'(MASS_CYC) : SW'(ERASE_CYC));
      C_PWT:   lim = SW'(PROG_CYC);
      C_HOLD:  lim = is_mass ? SW'(LONG_HOLD_CYC) : SW'(HOLD_CYC);
      C_RCV:   lim = SW'(RCV_CYC);
      default: lim = SW'(1);
    endcase
  end
  wire timed_out = wait_reg + SW'(1) >= lim;

  // sequence: select, read protect, latch, setup, high voltage, check, work, deselect, hold, off, recover
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      C_IDLE:  if (go) st_next = C_SEL;
      C_SEL:   if (link.ack) st_next = C_RDP;
      C_RDP:   if (link.ack) st_next = C_LAT;
      C_LAT:   if (link.ack) st_next = C_NVS;
      C_NVS:   if (timed_out) st_next = C_HVON;
      C_HVON:  if (link.ack) st_next = C_CHK;
      C_CHK:   if (link.ack) st_next = link.rdata[fep_pkg::CB_HV] ? C_TOP : C_ABORT;
      C_TOP:   if (timed_out) st_next = is_prog ? C_PWR : C_DESEL;
      C_PWR:   if (link.ack) st_next = C_PWT;
      C_PWT:   if (timed_out) st_next = (bix_reg == cnt_reg) ? C_DESEL : C_PWR;
      C_DESEL: if (link.ack) st_next = C_HOLD;
      C_HOLD:  if (timed_out) st_next = C_HVOFF;
      C_HVOFF: if (link.ack) st_next = C_RCV;
      C_RCV:   if (timed_out) st_next = C_IDLE;
      C_ABORT: if (link.ack) st_next = C_IDLE;
      default: st_next = C_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= C_IDLE;
      wait_reg <= '0;
      bix_reg <= 2'h0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      prot_reg <= 8'h00;
      devctl_reg <= 8'h00;
    end else begin
      st_reg <= st_next;
      wait_reg <= (st_next != st_reg) ? '0 : wait_reg + SW'(1);
      if (go) begin
        bix_reg <= 2'h0;
        done_reg <= 1'b0;
        refused_reg <= 1'b0;
      end
      if (st_reg == C_PWT && st_next == C_PWR) bix_reg <= bix_reg + 2'h1;
      if (st_reg == C_RDP && link.ack) prot_reg <= link.rdata;
      if (st_reg == C_CHK && link.ack) devctl_reg <= link.rdata;
      if (st_reg == C_CHK && link.ack && !link.rdata[fep_pkg::CB_HV]) refused_reg <= 1'b1;
      if (st_reg != C_IDLE && st_next == C_IDLE) done_reg <= 1'b1;
    end
  end

  // AXI registers; configuration is frozen while a sequence runs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= fep_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= fep_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      op_reg <= fep_pkg::OP_PAGE;
      cnt_reg <= 2'h0;
      addr_reg <= 16'h0000;
      data_reg <= 32'hffff_ffff;
    end else begin
      if (awvalid & awready) begin
        aw_held <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid & wready) begin
        w_held <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_map ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
        if (!busy && hit_cmd && wstrb_reg[0]) begin
          op_reg <= fep_pkg::fep_op_e'(wdata_reg[fep_pkg::CMD_OP_LSB +: 2]);
          cnt_reg <= wdata_reg[fep_pkg::CMD_CNT_LSB +: 2];
        end
        if (!busy && awaddr_reg == fep_pkg::REG_ADDR) addr_reg <= 16'(merge({16'h0000, addr_reg}, wdata_reg, wstrb_reg));
        if (!busy && awaddr_reg == fep_pkg::REG_DATA) data_reg <= merge(data_reg, wdata_reg, wstrb_reg);
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid & arready) begin
        rvalid <= 1'b1;
        rresp <= rd_map ? fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
        case (araddr)
          fep_pkg::REG_CMD:  rdata <= {26'h0, cnt_reg, 2'h0, op_reg};
          fep_pkg::REG_ADDR: rdata <= {16'h0000, addr_reg};
          fep_pkg::REG_DATA: rdata <= data_reg;
          fep_pkg::REG_STAT: rdata <= {8'h00, devctl_reg, prot_reg, 5'h00, refused_reg, done_reg, busy};
          default:           rdata <= 32'h0000_0000;
        endcase
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule : fep_ctrl
`default_nettype wire

// *** bench/fep_chk.sv ***
// link checker: request/answer timing and the controller's step order
// sees only the link signals between controller and device; one clock domain
`default_nettype none
module fep_chk #(parameter int SETUP_CYC = fep_pkg::SETUP_CYC) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        req,
  input wire logic        we,
  input wire logic        sel_ctl,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        ack
);
  logic       seen_prot, seen_lat, hv_on;
  logic [7:0] cnt;
  // link events, decoded on the edge where the device takes a request
  wire tk      = req && !ack;
  wire ctl_wr  = tk && we && sel_ctl;
  wire arr_wr  = tk && we && !sel_ctl;
  wire new_sel = ctl_wr && !wdata[3] && wdata[2:0] != 3'h0;
  wire hv_set  = ctl_wr && wdata[3] && wdata[2:0] != 3'h0;
  // step tracker; a new select restarts it so a stale read never counts
  always_ff @(posedge clk) begin
    if (!resetn || new_sel) begin
      seen_prot <= 1'b0;
      seen_lat <= 1'b0;
    end else begin
      if (tk && !we && !sel_ctl && addr == fep_pkg::PROT_ADDR) seen_prot <= 1'b1;
      if (arr_wr && seen_prot) seen_lat <= 1'b1;
    end
  end
  // high-voltage intent, and cycles since the last array write (saturating)
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hv_on <= 1'b0;
      cnt <= 8'h0;
    end else begin
      if (ctl_wr) hv_on <= wdata[3];
      cnt <= arr_wr ? 8'h0 : cnt + 8'(cnt != 8'hff);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_open; req && !ack; endsequence
  property p_ack_next; s_open |=> ack; endproperty
  property p_ack_once; ack |=> !ack; endproperty
  property p_hold; s_open |=> req && $stable(addr) && $stable(wdata) && $stable({we, sel_ctl}); endproperty
  property p_prot_first; hv_set |-> seen_prot; endproperty
  property p_latch_first; hv_set |-> seen_lat; endproperty
  property p_setup; hv_set |-> cnt >= SETUP_CYC - 1; endproperty
  property p_no_both; ctl_wr |-> !(wdata[0] && wdata[1]); endproperty
  property p_no_top; arr_wr && hv_on |-> addr != 16'hffff; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  a_hold: assert property (p_hold) else $error("request changed before ack");
  a_prot_first: assert property (p_prot_first) else $error("high voltage before protect read");
  a_latch_first: assert property (p_latch_first) else $error("high voltage before latch write");
  a_setup: assert property (p_setup) else $error("setup wait too short");
  a_no_both: assert property (p_no_both) else $error("program and erase asked together");
  a_no_top: assert property (p_no_top) else $error("top address written under high voltage");
endmodule : fep_chk
`default_nettype wire

// *** bench/tb_flash_erase_program_protect.sv ***
// bench: controller and device joined over the link, driven through AXI4-Lite
// assumes default delays on both ends; the array starts erased
`default_nettype none
module tb_flash_erase_program_protect;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, awready, wready, bvalid, arready, rvalid, hv_active, busy;
  logic        resetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, test_high_voltage = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0, protect_start_byte;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  int          miscompares = 0, n_compared = 0, cyc = 0;
  fep_if link ();
  fep_device fep_device_inst (.clk, .resetn, .link(link.dev), .test_high_voltage, .hv_active,
    .protect_start_byte, .busy);
  fep_ctrl fep_ctrl_inst (.clk, .resetn, .link(link.ctl), .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  fep_chk fep_chk_inst (.clk, .resetn, .req(link.req), .we(link.we), .sel_ctl(link.sel_ctl), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // sampled at the falling edge so the rising edge acts on settled handshakes
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(r));
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : axr
  // one single-byte sequence; waits for done and for the array walker to stop
  task automatic op(input fep_pkg::fep_op_e o, input logic [15:0] a, input logic [7:0] d, input logic rf,
                    input logic [7:0] ctl, input logic [7:0] pb);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    axw(fep_pkg::REG_ADDR, {16'h0, a}, fep_pkg::RESP_OKAY);
    axw(fep_pkg::REG_DATA, {24'h0, d}, fep_pkg::RESP_OKAY);
    axw(fep_pkg::REG_CMD, {23'h0, 1'b1, 6'h0, o}, fep_pkg::RESP_OKAY);
    st = 32'h0;
    for (n = 0; n < 4000 && st[1:0] !== 2'b10; n++) axr(fep_pkg::REG_STAT, st, r);
    for (n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge clk);
    chk("refused", 32'(rf), 32'(st[2]));
    chk("control seen", 32'(ctl), 32'(st[23:16]));
    chk("protect seen", 32'(pb), 32'(st[15:8]));
    chk("high voltage", 32'h0, 32'(hv_active));
    chk("done", 32'h2, 32'(st[1:0]));
    chk("busy", 32'h0, 32'(busy));
  endtask : op
  // unmapped places answer with an error; idle status after reset
  task automatic s_bus();
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h10, d, r);
    chk("unmapped rresp", 32'(fep_pkg::RESP_SLVERR), 32'(r));
    chk("unmapped rdata", 32'h0, d);
    axw(8'h10, 32'h0, fep_pkg::RESP_SLVERR);
    axr(fep_pkg::REG_STAT, d, r);
    chk("idle status", 32'h0, 32'(d[2:0]));
  endtask : s_bus
  task automatic s_prog_erase();
    op(fep_pkg::OP_PROG, 16'hf000, 8'h5a, 1'b0, 8'h09, 8'hff);
    op(fep_pkg::OP_PAGE, 16'hf000, 8'h00, 1'b0, 8'h0a, 8'hff);
  endtask : s_prog_erase
  // protect from ff80 upward and probe both sides of the boundary
  task automatic s_protect();
    op(fep_pkg::OP_PROG, fep_pkg::PROT_ADDR, 8'hfe, 1'b0, 8'h09, 8'hff);
    chk("protect byte", 32'h0000_00fe, 32'(protect_start_byte));
    op(fep_pkg::OP_MASS, 16'hee00, 8'h00, 1'b1, 8'h06, 8'hfe);
    op(fep_pkg::OP_PROG, 16'hff7f, 8'h33, 1'b0, 8'h09, 8'hfe);
    op(fep_pkg::OP_PROG, 16'hffc8, 8'h33, 1'b1, 8'h01, 8'hfe);
    op(fep_pkg::OP_PAGE, 16'hff80, 8'h00, 1'b1, 8'h02, 8'hfe);
  endtask : s_protect
  // the test voltage lets the protect byte page go, after which mass erase works
  task automatic s_unprotect();
    test_high_voltage <= 1'b1;
    op(fep_pkg::OP_PAGE, 16'hff80, 8'h00, 1'b0, 8'h0a, 8'hfe);
    test_high_voltage <= 1'b0;
    chk("protect byte", 32'h0000_00ff, 32'(protect_start_byte));
    op(fep_pkg::OP_MASS, 16'hee00, 8'h00, 1'b0, 8'h0e, 8'hff);
  endtask : s_unprotect
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    s_bus();
    s_prog_erase();
    s_protect();
    s_unprotect();
    wrap_up();
  end
endmodule : tb_flash_erase_program_protect
`default_nettype wire
